//--- shared/fcmet_params.svh
// Constants for the frame colour classifier and egress tag rewriter
`ifndef FCMET_PARAMS_SVH
`define FCMET_PARAMS_SVH
`define FCMET_GREEN        1'h0
`define FCMET_YELLOW       1'h1
`define FCMET_PCP_W        3
`define FCMET_DSCP_W       6
`define FCMET_PCP_ENTRIES  8
`define FCMET_DSCP_ENTRIES 64
`define FCMET_COLOR_RST    1'h0
`define FCMET_PCP_RST      3'h0
`endif

//--- shared/fcmet_pkg.sv
// Types shared by the colour classifier and egress tag rewriter
package fcmet_pkg;
  // Colour source selector
  typedef enum logic [1:0] {
    FCMET_SRC_FIXED,
    FCMET_SRC_DEI,
    FCMET_SRC_PCP,
    FCMET_SRC_DSCP
  } fcmet_src_e;
  // Layer 3 payload kind reported by the parser
  typedef enum logic [1:0] {
    FCMET_L3_NONE,
    FCMET_L3_IPV4,
    FCMET_L3_IPV6,
    FCMET_L3_OTHER
  } fcmet_l3_e;
endpackage

//--- verilog/fcmet_color_class.sv
// Ingress colour classifier, one result per frame
`include "fcmet_params.svh"
module fcmet_color_class #(
  parameter int PCP_W  = `FCMET_PCP_W,
  parameter int DSCP_W = `FCMET_DSCP_W
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       in_valid,
  input  wire fcmet_pkg::fcmet_src_e      color_source,
  input  wire logic                       fixed_color,
  input  wire logic [(1<<PCP_W)-1:0]      pcp_color_table,
  input  wire logic [(1<<DSCP_W)-1:0]     dscp_v4_color_table,
  input  wire logic [(1<<DSCP_W)-1:0]     dscp_v6_color_table,
  input  wire logic                       ctag_present,
  input  wire logic [PCP_W-1:0]           ctag_pcp,
  input  wire logic                       ctag_dei,
  input  wire fcmet_pkg::fcmet_l3_e       l3_kind,
  input  wire logic [DSCP_W-1:0]          dscp,
  output logic                            color_valid,
  output logic                            color
);
  import fcmet_pkg::*;

  logic next_color;   // Classified colour, one bit only
  logic next_valid;   // One result per accepted frame

  // Colour selection by source; every path yields green or yellow
  always_comb begin
    next_valid = in_valid;
    next_color = `FCMET_GREEN;
    unique case (color_source)
      FCMET_SRC_FIXED: begin
        next_color = fixed_color;
      end
      FCMET_SRC_DEI: begin
        // Untagged stays green
        if (ctag_present) begin
          next_color = ctag_dei ? `FCMET_YELLOW : `FCMET_GREEN;
        end else begin
          next_color = `FCMET_GREEN;
        end
      end
      FCMET_SRC_PCP: begin
        if (ctag_present) begin
          next_color = pcp_color_table[ctag_pcp];
        end else begin
          next_color = `FCMET_GREEN;
        end
      end
      FCMET_SRC_DSCP: begin
        // Separate tables per IP version; non-IP is green
        if (l3_kind == FCMET_L3_IPV4) begin
          next_color = dscp_v4_color_table[dscp];
        end else if (l3_kind == FCMET_L3_IPV6) begin
          next_color = dscp_v6_color_table[dscp];
        end else begin
          next_color = `FCMET_GREEN;
        end
      end
    endcase
  end

  // Result register, in frame order
  always_ff @(posedge clk) begin
    if (reset) begin
      color_valid <= 1'b0;
      color       <= `FCMET_COLOR_RST;
    end else begin
      color_valid <= next_valid;
      color       <= next_color;
    end
  end
endmodule

//--- verilog/fcmet_tagger.sv
// Top: ingress colour classification and egress tag rewrite
`include "fcmet_params.svh"
// Functional notes
// - Ingress colour is only green or yellow
// - Selector picks fixed, DEI, PCP or DSCP
// - Fixed source gives one colour always
// - DEI 0 green, DEI 1 yellow
// - DEI mode: untagged frame is green
// - PCP mode: table colours every PCP
// - PCP mode: untagged frame is green
// - DSCP mode: IPv4 table per DSCP
// - DSCP mode: separate IPv6 table
// - DSCP mode: non-IP frame is green
// - Classifier acts on ingress frames only
// - Egress uses meter colour when metered
// - Discard entry suppresses a non-internal egress frame when the map is enabled
// - Untagged ingress takes table PCP and DEI
// - Tagged ingress: per-field preserve or table
// - Internal OAM/control frames pass unrewritten
module fcmet_tagger #(
  parameter int PCP_W   = `FCMET_PCP_W,
  parameter int DSCP_W  = `FCMET_DSCP_W,
  parameter int EP_W    = 4,
  parameter int COS_W   = 2
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  // Ingress classification request
  input  wire logic                          ing_valid,
  input  wire logic [EP_W-1:0]               ing_endpoint,
  input  wire logic [COS_W-1:0]              ing_cos,
  input  wire logic                          ing_ctag_present,
  input  wire logic [PCP_W-1:0]              ing_pcp,
  input  wire logic                          ing_dei,
  input  wire fcmet_pkg::fcmet_l3_e          ing_l3_kind,
  input  wire logic [DSCP_W-1:0]             ing_dscp,
  // Ingress colour configuration of the selected endpoint
  input  wire fcmet_pkg::fcmet_src_e         color_source,
  input  wire logic                          fixed_color,
  input  wire logic [(1<<PCP_W)-1:0]         pcp_color_table,
  input  wire logic [(1<<DSCP_W)-1:0]        dscp_v4_color_table,
  input  wire logic [(1<<DSCP_W)-1:0]        dscp_v6_color_table,
  // Ingress classification result
  output logic                               ing_color_valid,
  output logic                               ing_color,
  output logic [EP_W-1:0]                    ing_color_endpoint,
  output logic [COS_W-1:0]                   ing_color_cos,
  // Egress rewrite request
  input  wire logic                          egr_valid,
  input  wire logic                          egr_internal,
  input  wire logic [COS_W-1:0]              egr_cos,
  input  wire logic                          egr_metered,
  input  wire logic                          egr_meter_color,
  input  wire logic                          egr_class_color,
  input  wire logic                          egr_ingress_tagged,
  input  wire logic [PCP_W-1:0]              egr_ingress_pcp,
  input  wire logic                          egr_ingress_dei,
  input  wire logic                          egr_out_tagged,
  // Egress configuration
  input  wire logic                          egress_map_enable,
  input  wire logic                          pcp_preserve,
  input  wire logic                          dei_preserve,
  input  wire logic [(2<<COS_W)*PCP_W-1:0]   egress_pcp_table,
  input  wire logic [(2<<COS_W)-1:0]         egress_dei_table,
  input  wire logic [(2<<COS_W)-1:0]         egress_discard_table,
  // Egress result
  output logic                               egr_out_valid,
  output logic                               egr_out_discard,
  output logic                               egr_out_rewrite,
  output logic [PCP_W-1:0]                   egr_out_pcp,
  output logic                               egr_out_dei
);
  import fcmet_pkg::*;

  localparam int ENTRIES = 2 << COS_W;   // Class times colour

  logic [EP_W-1:0]  ep_q;         // Endpoint tag kept beside colour
  logic [COS_W-1:0] cos_q;        // Class tag kept beside colour
  logic [EP_W-1:0]  next_ep;
  logic [COS_W-1:0] next_cos;

  // Classifier only ever sees the ingress request port
  fcmet_color_class #(
    .PCP_W (PCP_W),
    .DSCP_W(DSCP_W)
  ) u_class (
    .clk                (clk),
    .reset              (reset),
    .in_valid           (ing_valid),
    .color_source       (color_source),
    .fixed_color        (fixed_color),
    .pcp_color_table    (pcp_color_table),
    .dscp_v4_color_table(dscp_v4_color_table),
    .dscp_v6_color_table(dscp_v6_color_table),
    .ctag_present       (ing_ctag_present),
    .ctag_pcp           (ing_pcp),
    .ctag_dei           (ing_dei),
    .l3_kind            (ing_l3_kind),
    .dscp               (ing_dscp),
    .color_valid        (ing_color_valid),
    .color              (ing_color)
  );

  // Tags travel with the colour at the same latency
  always_comb begin
    next_ep  = ing_valid ? ing_endpoint : ep_q;
    next_cos = ing_valid ? ing_cos : cos_q;
  end

  // Tag registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ep_q  <= '0;
      cos_q <= '0;
    end else begin
      ep_q  <= next_ep;
      cos_q <= next_cos;
    end
  end

  assign ing_color_endpoint = ep_q;
  assign ing_color_cos      = cos_q;

  // Egress lookup state
  logic                   sel_color;     // Colour used for lookup
  logic [COS_W:0]         idx;           // Table index {class, colour}
  logic [PCP_W-1:0]       map_pcp;
  logic                   map_dei;
  logic                   map_discard;
  logic                   next_valid;
  logic                   next_discard;
  logic                   next_rewrite;
  logic [PCP_W-1:0]       next_pcp;
  logic                   next_dei;

  // Egress decision; internal pass first, then discard, then tag source per field
  always_comb begin
    sel_color    = egr_metered ? egr_meter_color : egr_class_color;
    idx          = {egr_cos, sel_color};
    map_pcp      = egress_pcp_table[idx*PCP_W +: PCP_W];
    map_dei      = egress_dei_table[idx];
    map_discard  = egress_discard_table[idx];
    next_valid   = egr_valid;
    next_discard = 1'b0;
    next_rewrite = 1'b0;
    next_pcp     = egr_ingress_pcp;
    next_dei     = egr_ingress_dei;
    if (egr_internal) begin
      // Provider-originated frames keep whatever tag they carry
      next_rewrite = 1'b0;
    end else if (egress_map_enable && map_discard) begin
      next_discard = 1'b1;
    end else if (egr_out_tagged && !egr_ingress_tagged) begin
      // Disabled map here is a configuration fault; table still used
      next_rewrite = 1'b1;
      next_pcp     = map_pcp;
      next_dei     = map_dei;
    end else if (egr_out_tagged) begin
      next_rewrite = 1'b1;
      next_pcp     = pcp_preserve ? egr_ingress_pcp : map_pcp;
      next_dei     = dei_preserve ? egr_ingress_dei : map_dei;
    end
  end

  // Egress result registers
  always_ff @(posedge clk) begin
    if (reset) begin
      egr_out_valid   <= 1'b0;
      egr_out_discard <= 1'b0;
      egr_out_rewrite <= 1'b0;
      egr_out_pcp     <= `FCMET_PCP_RST;
      egr_out_dei     <= 1'b0;
    end else begin
      egr_out_valid   <= next_valid && !next_discard;
      egr_out_discard <= next_valid && next_discard;
      egr_out_rewrite <= next_rewrite;
      egr_out_pcp     <= next_pcp;
      egr_out_dei     <= next_dei;
    end
  end
endmodule

//--- tb/fcmet_tagger_assertions.sv
// Checker of colour and tag rewrite behaviour at the top ports
module fcmet_tagger_checker (
  input wire logic                 clk,
  input wire logic                 reset,
  input wire logic                 ing_valid,
  input wire logic [3:0]           ing_endpoint,
  input wire logic                 ing_ctag_present,
  input wire logic                 ing_dei,
  input wire fcmet_pkg::fcmet_l3_e  ing_l3_kind,
  input wire fcmet_pkg::fcmet_src_e color_source,
  input wire logic                 fixed_color,
  input wire logic                 ing_color_valid,
  input wire logic                 ing_color,
  input wire logic [3:0]           ing_color_endpoint,
  input wire logic                 egr_valid,
  input wire logic                 egr_internal,
  input wire logic                 egr_ingress_tagged,
  input wire logic [2:0]           egr_ingress_pcp,
  input wire logic                 egr_ingress_dei,
  input wire logic                 egr_out_tagged,
  input wire logic                 pcp_preserve,
  input wire logic                 dei_preserve,
  input wire logic                 egr_out_valid,
  input wire logic                 egr_out_discard,
  input wire logic                 egr_out_rewrite,
  input wire logic [2:0]           egr_out_pcp,
  input wire logic                 egr_out_dei
);
  timeunit 1ns;
  timeprecision 1ps;
  import fcmet_pkg::*;
  // One domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  res_valid_a: assert property (ing_valid |=> ing_color_valid) else $error("no result");
  no_spur_a: assert property (!ing_valid |=> !ing_color_valid) else $error("extra result");
  tag_follow_a: assert property (
    ing_valid |=> ing_color_endpoint == $past(ing_endpoint)) else $error("endpoint lost");
  fixed_col_a: assert property (
    ing_valid && color_source == FCMET_SRC_FIXED |=> ing_color == $past(fixed_color))
    else $error("fixed colour wrong");
  dei_col_a: assert property (
    ing_valid && color_source == FCMET_SRC_DEI && ing_ctag_present
    |=> ing_color == $past(ing_dei)) else $error("dei colour wrong");
  untag_green_a: assert property (
    ing_valid && !ing_ctag_present && color_source inside {FCMET_SRC_DEI, FCMET_SRC_PCP}
    |=> !ing_color) else $error("untagged not green");
  nonip_green_a: assert property (
    ing_valid && color_source == FCMET_SRC_DSCP && !(ing_l3_kind inside {FCMET_L3_IPV4,
    FCMET_L3_IPV6}) |=> !ing_color) else $error("non ip not green");
  int_pass_a: assert property (
    egr_valid && egr_internal |=> egr_out_valid && !egr_out_rewrite
    && egr_out_pcp == $past(egr_ingress_pcp)) else $error("internal frame rewritten");
  pcp_keep_a: assert property (
    egr_valid && !egr_internal && egr_ingress_tagged && egr_out_tagged && pcp_preserve
    |=> egr_out_discard || egr_out_pcp == $past(egr_ingress_pcp)) else $error("pcp lost");
  dei_keep_a: assert property (
    egr_valid && !egr_internal && egr_ingress_tagged && egr_out_tagged && dei_preserve
    |=> egr_out_discard || egr_out_dei == $past(egr_ingress_dei)) else $error("dei lost");
  one_outcome_a: assert property (
    egr_valid |=> egr_out_valid ^ egr_out_discard) else $error("egress outcome wrong");
endmodule
bind fcmet_tagger fcmet_tagger_checker chk (.*);

//--- tb/fcmet_cfg_model.sv
// Provisioning logic model: PCP and DSCP colour tables and egress tables
module fcmet_cfg_model #(
  parameter logic [7:0]  PCP_TAB  = 8'h00,
  parameter logic [63:0] V4_TAB   = 64'h0000_0000_0000_0000,
  parameter logic [63:0] V6_TAB   = 64'h0000_0000_0000_0000,
  parameter logic [23:0] EPCP_TAB = 24'h00_0000,
  parameter logic [7:0]  EDEI_TAB = 8'h00,
  parameter logic [7:0]  EDIS_TAB = 8'h00
) (
  output logic [7:0]  pcp_color_table,
  output logic [63:0] dscp_v4_color_table,
  output logic [63:0] dscp_v6_color_table,
  output logic [23:0] egress_pcp_table,
  output logic [7:0]  egress_dei_table,
  output logic [7:0]  egress_discard_table,
  output logic        egress_map_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Tables are static: no endpoint switching in this model
  assign pcp_color_table      = PCP_TAB;
  assign dscp_v4_color_table  = V4_TAB;
  assign dscp_v6_color_table  = V6_TAB;
  assign egress_pcp_table     = EPCP_TAB;
  assign egress_dei_table     = EDEI_TAB;
  assign egress_discard_table = EDIS_TAB;
  // Map kept enabled: tagged egress always has a table
  assign egress_map_enable    = 1'b1;
endmodule

//--- tb/fcmet_tagger_tb.sv
// Self-checking bench for the colour classifier and tag rewriter
module fcmet_tagger_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fcmet_pkg::*;
  localparam logic [7:0]  PCT = 8'hA5;                  // PCP colours
  localparam logic [63:0] V4T = 64'h0000_0000_0002_28AE; // IPv4 yellow set
  localparam logic [63:0] V6T = 64'h0000_0004_0020_212E; // IPv6 yellow set
  localparam logic [23:0] EPT = 24'hFA_C688;             // Entry n gives PCP n
  localparam logic [7:0]  EDT = 8'hAA;                   // DEI follows colour
  localparam logic [7:0]  EXT = 8'h40;                   // Class 3 green dropped
  logic clk, reset, ing_valid, ing_ctag_present, ing_dei, fixed_color, ing_color_valid;
  logic ing_color, egr_valid, egr_internal, egr_metered, egr_meter_color, egr_class_color;
  logic egr_ingress_tagged, egr_ingress_dei, egr_out_tagged, egress_map_enable, pcp_preserve;
  logic dei_preserve, egr_out_valid, egr_out_discard, egr_out_rewrite, egr_out_dei;
  logic [3:0]  ing_endpoint, ing_color_endpoint;
  logic [1:0]  ing_cos, ing_color_cos, egr_cos;
  logic [2:0]  ing_pcp, egr_ingress_pcp, egr_out_pcp;
  logic [5:0]  ing_dscp;
  logic [7:0]  pcp_color_table, egress_dei_table, egress_discard_table;
  logic [63:0] dscp_v4_color_table, dscp_v6_color_table;
  logic [23:0] egress_pcp_table;
  fcmet_src_e  color_source;
  fcmet_l3_e   ing_l3_kind;
  int checks = 0;
  int miscompares = 0;
  int cycles = 0;
  fcmet_tagger dut (.*);
  fcmet_cfg_model #(.PCP_TAB(PCT), .V4_TAB(V4T), .V6_TAB(V6T), .EPCP_TAB(EPT),
    .EDEI_TAB(EDT), .EDIS_TAB(EXT)) cfg (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // One ingress descriptor; result judged one cycle later
  task automatic ing(input fcmet_src_e s, input logic t, input logic [2:0] p, input logic d,
                     input fcmet_l3_e l, input logic [5:0] q, input logic e);
    @(negedge clk);
    {ing_valid, color_source, ing_ctag_present, ing_pcp, ing_dei} = {1'b1, s, t, p, d};
    {ing_l3_kind, ing_dscp, ing_endpoint, ing_cos} = {l, q, 4'(checks), 2'(checks)};
    @(negedge clk);
    ing_valid = 1'b0;
    check(ing_color_valid === 1'b1 && ing_color === e && ing_color_endpoint === 4'(checks)
          && ing_color_cos === 2'(checks), "ingress colour");
  endtask
  // One egress frame; expectation built from the tables above
  task automatic egr(input logic [1:0] c, input logic m, mc, cc, it, ot, pp, dp, in);
    logic col, xd, xdis;
    logic [2:0] idx, xp;
    col = m ? mc : cc;
    idx = {c, col};
    xdis = EXT[idx] && !in;
    xp = (in || it && pp) ? ~idx : EPT[idx*3+:3];
    xd = (in || it && dp) ? ~col : EDT[idx];
    @(negedge clk);
    {egr_valid, egr_cos, egr_metered, egr_meter_color, egr_class_color} = {1'b1, c, m, mc, cc};
    {egr_ingress_tagged, egr_ingress_pcp, egr_ingress_dei, egr_out_tagged} = {it, ~idx, ~col, ot};
    {egr_internal, pcp_preserve, dei_preserve} = {in, pp, dp};
    @(negedge clk);
    egr_valid = 1'b0;
    if (xdis) check(egr_out_discard === 1'b1 && egr_out_valid === 1'b0, "no drop");
    else check(egr_out_valid === 1'b1 && egr_out_discard === 1'b0 && egr_out_rewrite ===
      (ot && !in) && (!(ot || in) || egr_out_pcp === xp && egr_out_dei === xd), "tag");
  endtask
  task automatic t_fixed();
    for (int c = 0; c < 2; c++) begin
      fixed_color = c[0];
      ing(FCMET_SRC_FIXED, 1'b1, 3'h0, ~c[0], FCMET_L3_IPV4, 6'h01, c[0]);
    end
  endtask
  task automatic t_tag();
    for (int k = 0; k < 4; k++)
      ing(FCMET_SRC_DEI, k[1], 3'h7, k[0], FCMET_L3_NONE, 6'h00, k[1] & k[0]);
    for (int p = 0; p < 9; p++)
      ing(FCMET_SRC_PCP, p < 8, 3'(p), 1'b1, FCMET_L3_IPV4, 6'h01, p < 8 && PCT[p[2:0]]);
  endtask
  task automatic t_dscp();
    for (int d = 0; d < 64; d++) begin
      ing(FCMET_SRC_DSCP, 1'b1, 3'h0, 1'b1, FCMET_L3_IPV4, 6'(d), V4T[d]);
      ing(FCMET_SRC_DSCP, 1'b0, 3'h0, 1'b1, FCMET_L3_IPV6, 6'(d), V6T[d]);
    end
    ing(FCMET_SRC_DSCP, 1'b1, 3'h0, 1'b1, FCMET_L3_NONE, 6'h01, 1'b0);
    ing(FCMET_SRC_DSCP, 1'b1, 3'h0, 1'b1, FCMET_L3_OTHER, 6'h02, 1'b0);
  endtask
  // Every class, colour and meter mix, with opposite PCP and DEI preserve on tagged frames, then edge cases
  task automatic t_egress();
    for (int k = 0; k < 64; k++)
      egr(k[1:0], k[3], k[2], ~k[2], k[4], 1'b1, k[5], k[4] ^ k[5], 1'b0);
    egr(2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    egr(2'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
  endtask
  task automatic stop_test();
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {reset, ing_valid, ing_ctag_present, ing_dei, fixed_color, egr_valid} = 6'h3F & 6'h20;
    {egr_internal, egr_metered, egr_meter_color, egr_class_color, egr_ingress_tagged} = '0;
    {egr_ingress_dei, egr_out_tagged, pcp_preserve, dei_preserve, egr_cos} = '0;
    {ing_endpoint, ing_cos, ing_pcp, ing_dscp, egr_ingress_pcp} = '0;
    color_source = FCMET_SRC_FIXED;
    ing_l3_kind = FCMET_L3_NONE;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    check(ing_color_valid === 1'b0 && egr_out_valid === 1'b0, "reset outputs");
    t_fixed();
    t_tag();
    t_dscp();
    t_egress();
    stop_test();
  end
endmodule
